// [verilog/sda_pkg.sv]
// constants for the reference pulse divider alignment block
package sda_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0]  align_control_idx   = 10'h1e8;
	localparam logic [9:0]  phase_offset_idx    = 10'h1e9;
	localparam logic [9:0]  tolerance_idx       = 10'h1ea;
	localparam logic [9:0]  sampling_select_idx = 10'h2bb;
	// reset values
	localparam logic [7:0]  align_control_rst   = 8'h00;
	localparam logic [7:0]  phase_offset_rst    = 8'h00;
	localparam logic [7:0]  tolerance_rst       = 8'h00;
	localparam logic [7:0]  sampling_select_rst = 8'h08;
	// control register bit positions
	localparam int          align_every_bit     = 0;
	localparam int          align_next_bit      = 1;
	localparam int          second_pulse_bit    = 2;
	localparam int          reset_every_bit     = 4;
	localparam int          reset_next_bit      = 5;
	localparam int          reset_second_bit    = 6;
	// field positions
	localparam int          offset_msb          = 4;
	localparam int          early_msb           = 7;
	localparam int          early_lsb           = 4;
	localparam int          late_msb            = 3;
	localparam int          sampling_select_bit = 3;
	// avalon response codes
	localparam logic [1:0]  resp_okay           = 2'h0;
	localparam logic [1:0]  resp_slave_error    = 2'h2;
endpackage : sda_pkg

// [verilog/sda_align.sv]
// reference pulse driven divider and multiframe clock alignment with register slave
//
// Behaviour
// - continuous mode realigns on every pulse outside the window
// - one-shot uses next pulse, then self-clears
// - second-pulse select skips first pulse in one-shot mode only, persists
// - one-shot phase reset resets NCO, self-clears
// - continuous phase reset resets NCO each alignment
// - multiframe clock delayed by offset frame periods
// - no realign when early within tolerance
// - no realign when late within tolerance
// - second-pulse phase reset resets NCO on second
// - sampling select picks reference or half-rate clock
`timescale 1ns/1ps
module sda_align #(
	parameter int FRAME_CYCLES = 4,  // core cycles per frame period
	parameter int LMFC_W       = 7   // multiframe period is 2**LMFC_W core cycles
) (
	// clock, reset and freeze
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	// avalon-mm slave, byte address
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [1:0]  avs_response,
	// reference pulse and synthesizer reference sampling strobe
	input  wire logic        ref_pulse_in,
	input  wire logic        synth_ref_tick,
	// alignment results
	output logic             divider_align,
	output logic             nco_phase_reset,
	output logic             lmfc_boundary
);

	////////////////////////////////////////////////////////////////////////////
	// register slave
	logic [7:0]  ctrl_q, ctrl_d;
	logic [7:0]  offset_q, offset_d;
	logic [7:0]  tol_q, tol_d;
	logic [7:0]  samp_q, samp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        wait_q, wait_d;
	logic [1:0]  resp_q, resp_d;
	logic [9:0]  idx;
	logic        hit;
	logic        wr_now;
	logic        ctrl_wr;
	logic [7:0]  wdat;
	// alignment state
	logic [LMFC_W-1:0] phase_q, phase_d;
	// last sampled pulse level, for rising edge detection
	logic        ref_prev_q, ref_prev_d;
	logic        first_seen_q, first_seen_d;
	logic        align_q, align_d;
	logic        nco_q, nco_d;
	logic        lmfc_q, lmfc_d;
	// decision terms
	logic        sample_en;
	logic        ref_event;
	logic        in_window;
	logic        one_shot_fire;
	logic        one_shot_skip;
	logic        cont_fire;
	logic        do_align;
	logic        do_nco;
	logic [LMFC_W-1:0] early_dist;
	logic [LMFC_W-1:0] lmfc_pos;

	assign idx    = avs_address[11:2];
	assign hit    = (idx == sda_pkg::align_control_idx) || (idx == sda_pkg::phase_offset_idx)
	             || (idx == sda_pkg::tolerance_idx) || (idx == sda_pkg::sampling_select_idx);
	// a write lands on the edge where waitrequest is seen low
	assign wr_now  = avs_write && !wait_q;
	assign wdat    = avs_writedata[7:0];
	assign ctrl_wr = wr_now && (idx == sda_pkg::align_control_idx);

	////////////////////////////////////////////////////////////////////////////
	// pulse sampling and window decision
	// select 1 samples on every core cycle, which already runs at half the adc rate;
	// select 0 samples only on synthesizer reference ticks
	assign sample_en = samp_q[sda_pkg::sampling_select_bit] ? 1'b1 : synth_ref_tick;
	assign ref_event = sample_en && ref_pulse_in && !ref_prev_q;
	// expected arrival is phase zero; one core cycle is two adc periods
	assign early_dist = LMFC_W'(0) - phase_q;
	assign in_window  = (phase_q == '0)
	                 || ({{(LMFC_W-4){1'b0}}, tol_q[sda_pkg::late_msb:0]} >= phase_q)
	                 || ({{(LMFC_W-4){1'b0}}, tol_q[sda_pkg::early_msb:sda_pkg::early_lsb]}
	                     >= early_dist);
	assign cont_fire     = ctrl_q[sda_pkg::align_every_bit];
	assign one_shot_skip = ctrl_q[sda_pkg::align_next_bit] && ctrl_q[sda_pkg::second_pulse_bit]
	                    && !first_seen_q;
	assign one_shot_fire = ctrl_q[sda_pkg::align_next_bit] && !one_shot_skip;
	assign do_align = ref_event && !in_window && (cont_fire || one_shot_fire);
	// nco reset rides the same decision as the divider realignment
	always_comb begin
		do_nco = 1'b0;
		if (do_align) begin
			if (cont_fire && ctrl_q[sda_pkg::reset_every_bit])
				do_nco = 1'b1;
			if (one_shot_fire && ctrl_q[sda_pkg::reset_next_bit]) begin
				if (!ctrl_q[sda_pkg::second_pulse_bit])
					do_nco = 1'b1;
				else if (ctrl_q[sda_pkg::reset_second_bit])
					do_nco = 1'b1;
			end
		end
	end
	// multiframe boundary sits offset frames after the reference position
	assign lmfc_pos = LMFC_W'(offset_q[sda_pkg::offset_msb:0] * FRAME_CYCLES);

	////////////////////////////////////////////////////////////////////////////
	// next state of registers and bus answer
	always_comb begin
		ctrl_d   = ctrl_q;
		offset_d = offset_q;
		tol_d    = tol_q;
		samp_d   = samp_q;
		rdata_d  = rdata_q;
		resp_d   = resp_q;
		wait_d   = 1'b1;
		// one wait cycle, then answer for a single cycle
		if ((avs_read || avs_write) && wait_q) begin
			wait_d  = 1'b0;
			resp_d  = hit ? sda_pkg::resp_okay : sda_pkg::resp_slave_error;
			rdata_d = 32'h0000_0000;
			if (avs_read) begin
				unique case (idx)
					sda_pkg::align_control_idx:   rdata_d[7:0] = ctrl_q;
					sda_pkg::phase_offset_idx:    rdata_d[7:0] = offset_q;
					sda_pkg::tolerance_idx:       rdata_d[7:0] = tol_q;
					sda_pkg::sampling_select_idx: rdata_d[7:0] = samp_q;
					default:                      rdata_d      = 32'h0000_0000;
				endcase
			end
		end
		// hardware self-clear of the one-shot bits
		if (ref_event && !in_window && one_shot_fire) begin
			ctrl_d[sda_pkg::align_next_bit] = 1'b0;
			ctrl_d[sda_pkg::reset_next_bit] = 1'b0;
		end
		// a software write in the same cycle wins so a set is never lost
		if (ctrl_wr)
			ctrl_d = wdat;
		if (wr_now && idx == sda_pkg::phase_offset_idx)
			offset_d = wdat;
		if (wr_now && idx == sda_pkg::tolerance_idx)
			tol_d = wdat;
		if (wr_now && idx == sda_pkg::sampling_select_idx)
			samp_d = wdat;
	end

	////////////////////////////////////////////////////////////////////////////
	// next state of alignment logic
	always_comb begin
		ref_prev_d   = sample_en ? ref_pulse_in : ref_prev_q;
		phase_d      = phase_q + LMFC_W'(1);
		first_seen_d = first_seen_q;
		align_d      = do_align;
		nco_d        = do_nco;
		lmfc_d       = (phase_q == lmfc_pos);
		// a control write restarts the count, but a pulse in that cycle still counts
		if (ctrl_wr)
			first_seen_d = 1'b0;
		// the first pulse of a second-pulse request is only remembered
		if (ref_event && one_shot_skip)
			first_seen_d = 1'b1;
		if (do_align) begin
			phase_d      = LMFC_W'(1); // pulse cycle becomes reference position
			first_seen_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state registers, frozen while ce is low
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q       <= sda_pkg::align_control_rst;
			offset_q     <= sda_pkg::phase_offset_rst;
			tol_q        <= sda_pkg::tolerance_rst;
			samp_q       <= sda_pkg::sampling_select_rst;
			rdata_q      <= 32'h0000_0000;
			resp_q       <= sda_pkg::resp_okay;
			wait_q       <= 1'b1;
			phase_q      <= '0;
			ref_prev_q   <= 1'b0;
			first_seen_q <= 1'b0;
			align_q      <= 1'b0;
			nco_q        <= 1'b0;
			lmfc_q       <= 1'b0;
		end else if (ce) begin
			ctrl_q       <= ctrl_d;
			offset_q     <= offset_d;
			tol_q        <= tol_d;
			samp_q       <= samp_d;
			rdata_q      <= rdata_d;
			resp_q       <= resp_d;
			wait_q       <= wait_d;
			phase_q      <= phase_d;
			ref_prev_q   <= ref_prev_d;
			first_seen_q <= first_seen_d;
			align_q      <= align_d;
			nco_q        <= nco_d;
			lmfc_q       <= lmfc_d;
		end
	end

	// outputs straight from flops
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign avs_response    = resp_q;
	assign divider_align   = align_q;
	assign nco_phase_reset = nco_q;
	assign lmfc_boundary   = lmfc_q;

endmodule : sda_align

// [verif/sda_ref_src.sv]
// partner model: reference pulse source and synthesizer sampling strobe
`timescale 1ns/1ps
module sda_ref_src (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// pulse and strobe
	output logic     ref_pulse_in,
	output logic     synth_ref_tick
);
	logic [1:0] div_q   = 2'h0;
	logic       tick_en = 1'h1;
	initial ref_pulse_in = 1'h0;
	// strobe on every fourth edge, locked to core_clk
	always @(posedge core_clk) begin
		div_q          <= div_q + 2'h1;
		synth_ref_tick <= resetn && tick_en && div_q == 2'h3;
	end
	// one pulse, wide enough for either sampling clock
	task automatic fire();
		@(posedge core_clk);
		ref_pulse_in <= 1'h1;
		repeat (8) @(posedge core_clk);
		ref_pulse_in <= 1'h0;
	endtask : fire
endmodule : sda_ref_src

// [verif/sda_align_chk.sv]
// port assertions for the reference pulse alignment block
`timescale 1ns/1ps
module sda_align_chk (
	// clock, reset, bus
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic        ce,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [11:0] avs_address,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	// pulse and results
	input wire logic        ref_pulse_in,
	input wire logic        divider_align,
	input wire logic        nco_phase_reset,
	input wire logic        lmfc_boundary
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic take;
	// bus request captured at this edge
	assign take = (avs_read || avs_write) && avs_waitrequest && ce;
	AST_NCO_SAME_EDGE: assert property (nco_phase_reset |-> divider_align)
		else $error("nco reset alone");
	AST_ALIGN_CAUSE: assert property (divider_align |-> $past(ref_pulse_in))
		else $error("align without pulse");
	AST_ALIGN_ONCE: assert property (divider_align |=> !divider_align)
		else $error("align too long");
	AST_LMFC_GAP: assert property (lmfc_boundary |=> !lmfc_boundary [*3])
		else $error("lmfc too close");
	AST_BUS_ANSWER: assert property (take |=> !avs_waitrequest) // one wait cycle
		else $error("no answer");
	AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest) // answer lasts one cycle
		else $error("answer too long");
	AST_BUS_ERR: assert property (take && avs_address == 12'h000 |=> avs_response == 2'h2) // unmapped
		else $error("no error response");
	AST_BUS_OKAY: assert property (take && avs_address[11:2] == sda_pkg::align_control_idx // mapped
		|=> avs_response == sda_pkg::resp_okay) else $error("bad response");
	cover property (divider_align && nco_phase_reset);
	cover property (lmfc_boundary);
	cover property (take && avs_address == 12'h000);
endmodule : sda_align_chk
////////////////////////////////////////
bind sda_align sda_align_chk i_sda_align_chk (.core_clk(core_clk), .resetn(resetn), .ce(ce),
	.avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
	.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
	.ref_pulse_in(ref_pulse_in), .divider_align(divider_align),
	.nco_phase_reset(nco_phase_reset), .lmfc_boundary(lmfc_boundary));

// [verif/test_ref_pulse_tolerance_window_divider_alignment.sv]
// self-checking bench for the reference pulse alignment block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("BAD %0t %h %h", $time, g, e); end end
module test_ref_pulse_tolerance_window_divider_alignment;
	localparam logic [9:0] ctl = sda_pkg::align_control_idx;
	localparam logic [9:0] ofs = sda_pkg::phase_offset_idx;
	localparam logic [9:0] tol = sda_pkg::tolerance_idx;
	localparam logic [9:0] sel = sda_pkg::sampling_select_idx;
	logic        clk = 1'h0, rstn = 1'h0, rd = 1'h0, wr = 1'h0, wrq, algn, ncor, lmfc, rp, tk;
	logic [11:0] adr = 12'h000;
	logic [31:0] wd  = 32'h0, rdat;
	logic [1:0]  resp;
	logic        en  = 1'h1;
	int errors = 0, comparisons = 0, aligns = 0, resets = 0, cyc = 0, al_t = 0, lm_t = 0;
	sda_align #(.FRAME_CYCLES(4)) i_sda_align (.core_clk(clk), .resetn(rstn), .ce(en),
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_readdata(rdat), .avs_waitrequest(wrq), .avs_response(resp), .ref_pulse_in(rp),
		.synth_ref_tick(tk), .divider_align(algn), .nco_phase_reset(ncor),
		.lmfc_boundary(lmfc));
	sda_ref_src i_sda_ref_src (.core_clk(clk), .resetn(rstn), .ref_pulse_in(rp),
		.synth_ref_tick(tk));
	// clock
	always #5 clk = ~clk;
	// count the alignment outputs and note their cycle
	always @(posedge clk) begin
		cyc    <= cyc + 1;
		aligns <= aligns + int'(algn === 1'h1);
		resets <= resets + int'(ncor === 1'h1);
		if (algn === 1'h1) al_t <= cyc;
		if (lmfc === 1'h1) lm_t <= cyc;
	end
	// verdict and end of run
	task automatic print_verdict();
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	// one access; d is write data or expected read data
	task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		adr <= {i, 2'h0};
		wd  <= {24'h0, d};
		wr  <= w;
		rd  <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wrq !== 1'h0 && n < 50);
		if (wrq !== 1'h0) begin
			errors++;
			print_verdict();
		end
		`CHK(resp, er)
		if (!w) `CHK(rdat, {24'h0, d})
		rd <= 1'h0;
		wr <= 1'h0;
	endtask : bus
	// one reference pulse, then count what it caused
	task automatic pulse(input int ea, input int er);
		int a0, r0;
		a0 = aligns;
		r0 = resets;
		i_sda_ref_src.fire();
		repeat (2) @(posedge clk);
		`CHK(aligns - a0, ea)
		`CHK(resets - r0, er)
	endtask : pulse
	////////////////////////////////////////
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		bus(1'h0, ctl, 8'h00, 2'h0);
		bus(1'h0, ofs, 8'h00, 2'h0);
		bus(1'h0, tol, 8'h00, 2'h0);
		bus(1'h0, sel, 8'h08, 2'h0);
		bus(1'h0, 10'h000, 8'h00, 2'h2);
		bus(1'h1, ofs, 8'he2, 2'h0);
		bus(1'h0, ofs, 8'he2, 2'h0);
		pulse(0, 0);
		bus(1'h1, ctl, 8'h22, 2'h0);
		pulse(1, 1);
		bus(1'h0, ctl, 8'h00, 2'h0);
		pulse(0, 0);
		bus(1'h1, ctl, 8'h11, 2'h0);
		pulse(1, 1);
		repeat (8) @(posedge clk);
		// offset of 2 frames, 4 core cycles each
		`CHK(lm_t - al_t, 2 * 4)
		pulse(1, 1);
		bus(1'h1, ctl, 8'h21, 2'h0);
		pulse(1, 0);
		bus(1'h1, ctl, 8'h66, 2'h0);
		pulse(0, 0);
		pulse(1, 1);
		bus(1'h0, ctl, 8'h44, 2'h0);
		// second pulse without its own phase-reset bit leaves the nco alone
		bus(1'h1, ctl, 8'h26, 2'h0);
		pulse(0, 0);
		pulse(1, 0);
		bus(1'h0, ctl, 8'h04, 2'h0);
		// reset-every without continuous mode has no effect
		bus(1'h1, ctl, 8'h12, 2'h0);
		pulse(1, 0);
		bus(1'h1, tol, 8'h0f, 2'h0);
		repeat (40) @(posedge clk);
		bus(1'h1, ctl, 8'h01, 2'h0);
		pulse(1, 0);
		pulse(0, 0);
		bus(1'h1, tol, 8'hf0, 2'h0);
		repeat (95) @(posedge clk);
		pulse(0, 0);
		repeat (30) @(posedge clk);
		pulse(1, 0);
		i_sda_ref_src.tick_en <= 1'h0;
		bus(1'h1, sel, 8'h00, 2'h0);
		pulse(0, 0);
		i_sda_ref_src.tick_en <= 1'h1;
		pulse(1, 0);
		// a low clock enable freezes the block through a whole pulse
		repeat (20) @(posedge clk);
		en <= 1'h0;
		pulse(0, 0);
		en <= 1'h1;
		pulse(1, 0);
		print_verdict();
	end
endmodule : test_ref_pulse_tolerance_window_divider_alignment
